// [logic/bms_pkg.sv]
/*
 * Shared types and constants for the boot mode select block.
 * Assumes one core clock and an asynchronous active-low reset.
 */
package bms_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned SYNC_STAGES   = 2;   // Flops per pin synchroniser
    localparam int unsigned SETTLE_CYCLES = SYNC_STAGES; // Fill after release
    localparam int unsigned CNT_W         = 2;   // Settle counter width
    localparam logic [CNT_W-1:0] SETTLE_LAST =
        CNT_W'(SETTLE_CYCLES);                   // Count at capture edge

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] PINS_RESET = 3'h0;    // Synchroniser reset level
    localparam logic       CS_IDLE_N  = 1'h1;    // Chip select idle level

    // ------------------------------------------------------------
    // Pin bundle, positions inside the packed struct
    // ------------------------------------------------------------
    typedef struct packed {
        logic eprom_boot_strap;                  // Bit 2
        logic link_boot_strap;                   // Bit 1
        logic boot_memory_select;                // Bit 0
    } bms_pins_s;

    // Synchroniser state: two stages of the pin bundle
    typedef struct packed {
        bms_pins_s meta;                         // First stage, feeds stage 2
        bms_pins_s sync;                         // Second stage, safe to use
    } bms_sync_s;

    // ------------------------------------------------------------
    // Boot modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BMS_MODE_EPROM = 3'h0,                   // External EPROM
        BMS_MODE_HOST  = 3'h1,                   // Host processor
        BMS_MODE_SPI   = 3'h2,                   // Serial boot over SPI
        BMS_MODE_LINK  = 3'h3,                   // Link port
        BMS_MODE_NONE  = 3'h4,                   // Run from external memory
        BMS_MODE_RESV  = 3'h5                    // Reserved strap setting
    } bms_mode_e;

    // Sampling state machine
    typedef enum logic [1:0] {
        BMS_ST_SETTLE = 2'h0,                    // Waiting for sync fill
        BMS_ST_LOCKED = 2'h1                     // Mode captured, frozen
    } bms_state_e;

    // All state of the top module
    typedef struct packed {
        bms_state_e       state;                 // Sampler state
        logic [CNT_W-1:0] cnt;                   // Settle counter
        bms_mode_e        mode;                  // Latched boot mode
        logic             valid;                 // Mode has been captured
        logic             reserved;              // Reserved straps seen
        logic             sel_oe;                // Select pin drive enable
        logic             sel_out;               // Select pin drive level
    } bms_state_s;

endpackage

// [logic/bms_pin_sync.sv]
/*
 * Two-flop synchroniser for the three boot pins.
 * Assumes the pins are asynchronous to clk and quasi-static around reset.
 */
`timescale 1ns/1ps

module bms_pin_sync
    import bms_pkg::*;
(
    input  wire logic      clk,              // Core clock
    input  wire logic      reset_n,          // Async reset, active low
    input  wire bms_pins_s pins_in,          // Raw pin levels
    output bms_pins_s      pins_sync         // Synchronised levels
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bms_sync_s st_r;                         // Both stages
    bms_sync_s st_nxt;                       // Next value

    // Shift: stage 1 is read only by stage 2
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = pins_in;
        st_nxt.sync = st_r.meta;
    end

    // Register, reset to a constant only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= {PINS_RESET, PINS_RESET};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pins_sync = st_r.sync;

endmodule

// [logic/bms_boot_select.sv]
/*
 * Boot mode selection: samples the two boot straps and the boot memory
 * select pin after reset release, decodes and freezes the boot mode, and
 * drives the select pin as EPROM chip select when booting from EPROM.
 * Assumes the straps are held steady for at least the settle window after
 * reset release and that the pad ring resolves the select pin from oe.
 */
`timescale 1ns/1ps

// Summary of operation
// RQ1: EPROM strap high: EPROM boot, drive select
// RQ2: Straps low, select high: host boot
// RQ3: Link strap, select low: SPI boot
// RQ4: Link strap, select high: link port boot
// RQ5: All low: no load, run external memory
// RQ6: Both straps high is reserved, never tied
// RQ7: Sample at reset release, then freeze mode
module bms_boot_select
    import bms_pkg::*;
(
    input  wire logic clk,                   // Core clock, 125 MHz
    input  wire logic reset_n,               // Async reset, active low
    input  wire logic eprom_boot_strap,      // EPROM boot strap pin
    input  wire logic link_boot_strap,       // Link boot strap pin
    input  wire logic boot_memory_select_i,  // Select pin input level
    output logic      boot_memory_select_o,  // Select pin drive level
    output logic      boot_memory_select_oe, // Select pin drive enable
    input  wire logic eprom_select_req,      // Loader wants EPROM selected
    output bms_mode_e boot_mode,             // Latched boot mode
    output logic      boot_mode_valid,       // Mode captured
    output logic      boot_mode_reserved     // Reserved straps seen
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    bms_pins_s pins_raw;                     // Raw pin bundle
    bms_pins_s pins;                         // Synchronised bundle

    assign pins_raw = '{eprom_boot_strap:   eprom_boot_strap,
                        link_boot_strap:    link_boot_strap,
                        boot_memory_select: boot_memory_select_i};

    bms_pin_sync u_sync (
        .clk       (clk),
        .reset_n   (reset_n),
        .pins_in   (pins_raw),
        .pins_sync (pins)
    );

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    // Pure decode of the synchronised pins; used only at capture.
    function automatic bms_mode_e decode_mode(input bms_pins_s p);
        bms_mode_e m;
        m = BMS_MODE_RESV;
        case ({p.eprom_boot_strap, p.link_boot_strap})
            2'h2: begin
                m = BMS_MODE_EPROM;                           // RQ1
            end
            2'h0: begin
                if (p.boot_memory_select) begin
                    m = BMS_MODE_HOST;                        // RQ2
                end else begin
                    m = BMS_MODE_NONE;                        // RQ5
                end
            end
            2'h1: begin
                if (p.boot_memory_select) begin
                    m = BMS_MODE_LINK;                        // RQ4
                end else begin
                    m = BMS_MODE_SPI;                         // RQ3
                end
            end
            default: begin
                // Both straps high: reserved, select stays an input
                m = BMS_MODE_RESV;                            // RQ6
            end
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bms_state_s st_r;                        // Registered state
    bms_state_s st_nxt;                      // Next state

    // Sampler: wait for the synchronisers to fill, capture once, freeze.
    // Freezing matters because the select pin turns into an output in
    // EPROM mode and would otherwise feed back into the decode.
    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            BMS_ST_SETTLE: begin
                // Select pin is an input until the mode is known
                st_nxt.sel_oe  = 1'h0;
                st_nxt.sel_out = CS_IDLE_N;
                if (st_r.cnt == SETTLE_LAST) begin
                    st_nxt.state    = BMS_ST_LOCKED;              // RQ7
                    st_nxt.mode     = decode_mode(pins);          // RQ7
                    st_nxt.valid    = 1'h1;
                    st_nxt.reserved = (decode_mode(pins) == BMS_MODE_RESV);
                    st_nxt.sel_oe   =
                        (decode_mode(pins) == BMS_MODE_EPROM);    // RQ1
                end else begin
                    st_nxt.cnt = st_r.cnt + CNT_W'(1);
                end
            end
            BMS_ST_LOCKED: begin
                // Mode held until the next reset, pins ignored
                if (st_r.mode == BMS_MODE_EPROM) begin
                    st_nxt.sel_oe  = 1'h1;                        // RQ1
                    st_nxt.sel_out = ~eprom_select_req;           // RQ1
                end else begin
                    st_nxt.sel_oe  = 1'h0;
                    st_nxt.sel_out = CS_IDLE_N;
                end
            end
            default: begin
                // Unreachable codes recover by re-sampling
                st_nxt.state = BMS_ST_SETTLE;
                st_nxt.cnt   = '0;
            end
        endcase
    end

    // Register the whole state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.state    <= BMS_ST_SETTLE;
            st_r.cnt      <= '0;
            st_r.mode     <= BMS_MODE_NONE;
            st_r.valid    <= 1'h0;
            st_r.reserved <= 1'h0;
            st_r.sel_oe   <= 1'h0;
            st_r.sel_out  <= CS_IDLE_N;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from flops
    // ------------------------------------------------------------
    assign boot_memory_select_o  = st_r.sel_out;
    assign boot_memory_select_oe = st_r.sel_oe;
    assign boot_mode             = st_r.mode;
    assign boot_mode_valid       = st_r.valid;
    assign boot_mode_reserved    = st_r.reserved;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    eprom_mode_a: assert property ( // RQ1
        $rose(st_r.valid) && $past(pins.eprom_boot_strap)
            && !$past(pins.link_boot_strap)
        |-> st_r.mode == BMS_MODE_EPROM && st_r.sel_oe
            ##1 st_r.sel_out == ~$past(eprom_select_req))
        else $error("EPROM straps did not give EPROM boot");

    host_mode_a: assert property ( // RQ2
        $rose(st_r.valid) && !$past(pins.eprom_boot_strap)
            && !$past(pins.link_boot_strap)
            && $past(pins.boot_memory_select)
        |-> st_r.mode == BMS_MODE_HOST && !st_r.sel_oe)
        else $error("host straps did not give host boot");

    spi_mode_a: assert property ( // RQ3
        $rose(st_r.valid) && !$past(pins.eprom_boot_strap)
            && $past(pins.link_boot_strap)
            && !$past(pins.boot_memory_select)
        |-> st_r.mode == BMS_MODE_SPI && !st_r.sel_oe)
        else $error("SPI straps did not give SPI boot");

    link_mode_a: assert property ( // RQ4
        $rose(st_r.valid) && !$past(pins.eprom_boot_strap)
            && $past(pins.link_boot_strap)
            && $past(pins.boot_memory_select)
        |-> st_r.mode == BMS_MODE_LINK)
        else $error("link straps did not give link boot");

    none_mode_a: assert property ( // RQ5
        $rose(st_r.valid) && !$past(pins.eprom_boot_strap)
            && !$past(pins.link_boot_strap)
            && !$past(pins.boot_memory_select)
        |-> st_r.mode == BMS_MODE_NONE && !st_r.reserved)
        else $error("all-low straps did not give no boot");

    select_input_a: assert property ( // RQ6
        st_r.mode != BMS_MODE_EPROM |-> !st_r.sel_oe)
        else $error("select pin driven outside EPROM boot");

    mode_frozen_a: assert property ( // RQ7
        st_r.valid |=> st_r.valid && $stable(st_r.mode) [*8])
        else $error("boot mode changed after capture");

    // Valid is loaded at the third edge after release, so the sampled
    // value first shows it at the fourth edge; edges 1 to 3 see it low
    capture_time_a: assert property ( // RQ7
        $rose(reset_n) |-> !st_r.valid [*3] ##1 st_r.valid)
        else $error("capture not at settle end");

    // Loader request reaches the pin one cycle later, EPROM boot only
    select_follow_a: assert property ( // RQ1
        st_r.valid && st_r.mode == BMS_MODE_EPROM
        |=> st_r.sel_oe && st_r.sel_out == ~$past(eprom_select_req))
        else $error("EPROM select did not follow the loader");

    // Both straps high: flag raised, select pin left as an input
    reserved_mode_a: assert property ( // RQ6
        $rose(st_r.valid) && $past(pins.eprom_boot_strap)
            && $past(pins.link_boot_strap)
        |-> st_r.mode == BMS_MODE_RESV && st_r.reserved && !st_r.sel_oe)
        else $error("reserved straps not reported");

    eprom_cov_c: cover property ($rose(st_r.valid) && st_r.sel_oe);
    host_cov_c:  cover property ($rose(st_r.valid)
                                 && st_r.mode == BMS_MODE_HOST);
    resv_cov_c:  cover property ($rose(st_r.valid) && st_r.reserved);
    spi_cov_c:   cover property ($rose(st_r.valid)
                                 && st_r.mode == BMS_MODE_SPI);
    link_cov_c:  cover property ($rose(st_r.valid)
                                 && st_r.mode == BMS_MODE_LINK);

endmodule

// [tb/bms_boot_source.sv]
/*
 * Far-side model: the board straps and the boot source on the select pin.
 * Assumes the device drives the select pin only while its enable is high.
 */
`timescale 1ns/1ps

module bms_boot_source
    import bms_pkg::*;
(
    input  wire logic      clk,           // Core clock
    input  wire bms_mode_e mode_sel,      // Boot source to present
    input  wire logic      break_rule,    // Tie both straps high on purpose
    input  wire logic      sel_o,         // Device select drive level
    input  wire logic      sel_oe,        // Device select drive enable
    output logic           eprom_strap,   // EPROM strap level
    output logic           link_strap,    // Link strap level
    output logic           sel_wire,      // Resolved select pin level
    output logic           eprom_cs_seen  // EPROM sees its select low
);
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    logic float_r = 1'h0;                 // Undriven pin, changes each cycle
    logic src_drv;                        // Source drives the select pin
    logic src_lvl;                        // Level the source drives

    // Nobody driving: a toggling level, so no value is settled by chance
    always @(posedge clk) begin
        float_r <= ~float_r;
    end

    // Strap and select levels for the chosen source
    always_comb begin
        eprom_strap = (mode_sel == BMS_MODE_EPROM) | break_rule;
        link_strap  = (mode_sel inside {BMS_MODE_SPI, BMS_MODE_LINK})
                    | break_rule;
        src_drv = (mode_sel != BMS_MODE_EPROM) | break_rule;
        src_lvl = mode_sel inside {BMS_MODE_HOST, BMS_MODE_LINK};
        // Device drive wins; EPROM source drives back only when break_rule is set
        sel_wire = sel_oe ? sel_o : (src_drv ? src_lvl : float_r);
        eprom_cs_seen = (mode_sel == BMS_MODE_EPROM) & sel_oe & ~sel_o;
    end
endmodule

// [tb/bms_boot_select_tb.sv]
/*
 * Self-checking bench for the boot mode selector.
 * Assumes the capture lands at the third edge after reset release.
 */
`timescale 1ns/1ps

module bms_boot_select_tb;
    import bms_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic      clk     = 1'h0;            // Core clock, 8 ns
    logic      reset_n = 1'h0;            // Async reset, active low
    logic      req     = 1'h0;            // Loader EPROM select request
    logic      brk     = 1'h0;            // Deliberate reserved straps
    bms_mode_e src     = BMS_MODE_NONE;   // Source the model presents
    logic      e_strap;                   // EPROM strap
    logic      l_strap;                   // Link strap
    logic      sel_w;                     // Resolved select pin
    logic      sel_o;                     // Device select level
    logic      sel_oe;                    // Device select enable
    logic      cs_seen;                   // EPROM select observed
    bms_mode_e mode;                      // Latched mode
    logic      valid;                     // Mode captured
    logic      resv;                      // Reserved flag
    int        err_total = 0;             // Mismatches
    int        cmp_count = 0;             // Comparisons
    int        cyc       = 0;             // Cycle count for the timeout

    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    bms_boot_select i_bms_boot_select (
        .clk(clk), .reset_n(reset_n), .eprom_boot_strap(e_strap),
        .link_boot_strap(l_strap), .boot_memory_select_i(sel_w),
        .boot_memory_select_o(sel_o), .boot_memory_select_oe(sel_oe),
        .eprom_select_req(req), .boot_mode(mode),
        .boot_mode_valid(valid), .boot_mode_reserved(resv));

    bms_boot_source i_bms_boot_source (
        .clk(clk), .mode_sel(src), .break_rule(brk), .sel_o(sel_o),
        .sel_oe(sel_oe), .eprom_strap(e_strap), .link_strap(l_strap),
        .sel_wire(sel_w), .eprom_cs_seen(cs_seen));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Compare and count; four-state so unknowns never match
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far above the 77 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            end_of_test();
        end
    end

    // Step n edges, then drive and sample 1 ns later
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Reset, present a source, release, check capture timing
    task automatic boot(input bms_mode_e m, input logic b);
        reset_n = 1'h0;
        src     = m;
        brk     = b;
        req     = 1'h0;
        tick(2);
        chk(mode, BMS_MODE_NONE, "reset mode");
        chk({sel_oe, sel_o, valid, resv}, 4'h4, "reset outputs");
        reset_n = 1'h1;
        tick(2);
        chk(valid, 1'h0, "valid too early");
        tick(1);
        chk(valid, 1'h1, "valid missing at third edge");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every legal strap setting decodes to its mode
    task automatic t_modes;
        bms_mode_e m;
        for (int i = 0; i < 5; i++) begin
            m = bms_mode_e'(i);
            boot(m, 1'h0);
            chk(mode, m, "decoded mode");
            chk(sel_oe, m == BMS_MODE_EPROM, "select enable");
            chk(resv, 1'h0, "reserved flag");
        end
    endtask

    // Both straps high: reserved, select stays an input
    task automatic t_reserved;
        boot(BMS_MODE_LINK, 1'h1);
        chk(mode, BMS_MODE_RESV, "reserved mode");
        chk({resv, sel_oe}, 2'h2, "reserved flags");
    endtask

    // EPROM select follows the loader, ignored in host boot
    task automatic t_eprom_cs;
        boot(BMS_MODE_EPROM, 1'h0);
        req = 1'h1;
        tick(1);
        chk({sel_o, cs_seen}, 2'h1, "select not low");
        req = 1'h0;
        tick(1);
        chk({sel_o, cs_seen}, 2'h2, "select not released");
        boot(BMS_MODE_HOST, 1'h0);
        req = 1'h1;
        tick(2);
        chk({sel_oe, sel_o}, 2'h1, "select driven in host");
    endtask

    // Pin changes after capture leave the mode alone
    task automatic t_freeze;
        boot(BMS_MODE_SPI, 1'h0);
        src = BMS_MODE_LINK;
        tick(5);
        chk(mode, BMS_MODE_SPI, "mode changed after capture");
        brk = 1'h1;
        tick(4);
        chk({resv, valid}, 2'h1, "late reserved seen");
        boot(BMS_MODE_EPROM, 1'h0);
        src = BMS_MODE_NONE;
        tick(4);
        chk({mode, sel_oe}, {BMS_MODE_EPROM, 1'h1}, "eprom lost");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(10);
        t_modes();
        t_reserved();
        t_eprom_cs();
        t_freeze();
        end_of_test();
    end
endmodule
